//--- scc_defs.svh
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: register index = printed offset, byte address = 4 * index
// Notes: definitions only
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// ----------------------------------------
// register indices
// ----------------------------------------
`define SCC_IDX_MODE 16'hffb0
`define SCC_IDX_DIV 16'hffb1
`define SCC_IDX_CTRL 16'hffb2
`define SCC_IDX_TXH 16'hffb3
`define SCC_IDX_STAT 16'hffb4
`define SCC_IDX_RXH 16'hffb5
`define SCC_IDX_CMODE 16'hffb6

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCC_MODE_GSM 7
`define SCC_MODE_ODD 4
`define SCC_CTRL_TXEN 5
`define SCC_CTRL_RXEN 4
`define SCC_CTRL_CKHI 1
`define SCC_CTRL_CKLO 0
`define SCC_ST_TXE 7
`define SCC_ST_RXF 6
`define SCC_ST_OVR 5
`define SCC_ST_RTE 4
`define SCC_ST_PER 3
`define SCC_ST_TXC 2
`define SCC_CM_MSB 3
`define SCC_CM_INV 2
`define SCC_CM_SEL 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCC_RST_MODE 8'h00
`define SCC_RST_DIV 8'h00
`define SCC_RST_CTRL 8'h00
`define SCC_RST_STAT 8'h84
`define SCC_RST_CMODE 8'h00

// ----------------------------------------
// frame timing: card clocks per etu, then half bit times from start edge
// ----------------------------------------
`define SCC_CARD_CLK_PER_ETU 372
`define SCC_H_LAST_BIT 5'd19
`define SCC_H_ERR_START 5'd21
`define SCC_H_ERR_END 5'd23
`define SCC_H_TXC_GSM 5'd21
`define SCC_H_TXC_REG 5'd24
`define SCC_H_RETRY 5'd27

`endif

//--- scc_pkg.sv
// Purpose: types shared by the card serial block
// Assumes: nothing
// Notes: one-hot engine states
package scc_pkg;

  typedef enum logic [4:0] {
    SCC_IDLE = 5'b00001,
    SCC_TX = 5'b00010,
    SCC_TX_WAIT = 5'b00100,
    SCC_RX = 5'b01000,
    SCC_RX_END = 5'b10000
  } scc_state_t;

endpackage

//--- scc_baud.sv
// Purpose: bit-rate generator and card clock source
// Assumes: phi_tick_i pulses once per divided system clock
// Notes: card clock half period is 4^n*(N+1) divided clocks
`timescale 1ns/1ns
`include "scc_defs.svh"
module scc_baud #(
  parameter int CLK_PER_ETU = `SCC_CARD_CLK_PER_ETU
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic phi_tick_i,
  input wire logic restart_i,
  input wire logic [1:0] prescale_sel_i,
  input wire logic [7:0] rate_divisor_i,
  // outputs
  output logic card_clk_o,
  output logic half_tick_o
);

  logic [5:0] pre_cnt;
  logic [7:0] div_cnt;
  logic [8:0] tgl_cnt;
  logic pre_wrap;
  logic div_wrap;
  initial begin
    if (CLK_PER_ETU < 2 || CLK_PER_ETU > 511) $error("scc_baud: CLK_PER_ETU out of range");
  end

  // ----------------------------------------
  // prescaler: 4^n divided clocks per step
  // ----------------------------------------
  assign pre_wrap = phi_tick_i && (pre_cnt == 6'h00);
  assign div_wrap = pre_wrap && (div_cnt == 8'h00);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_cnt <= 6'h00;
    end else if (pre_wrap) begin
      pre_cnt <= 6'((1 << (2 * prescale_sel_i)) - 1); // [R17] [R16]
    end else if (phi_tick_i) begin // [R19]
      pre_cnt <= pre_cnt - 6'h01;
    end
  end

  // down-counter reloads with the divisor
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_cnt <= 8'h00;
    end else if (div_wrap) begin
      div_cnt <= rate_divisor_i; // [R22]
    end else if (pre_wrap) begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  // ----------------------------------------
  // card clock and half bit-time tick
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      card_clk_o <= 1'b0;
    end else if (div_wrap) begin
      card_clk_o <= ~card_clk_o; // [R15]
    end
  end

  // restart only realigns the bit phase; card clock keeps running
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tgl_cnt <= 9'h000;
      half_tick_o <= 1'b0;
    end else if (restart_i) begin
      tgl_cnt <= 9'h000;
      half_tick_o <= 1'b0;
    end else if (div_wrap && tgl_cnt == 9'(CLK_PER_ETU - 1)) begin
      tgl_cnt <= 9'h000;
      half_tick_o <= 1'b1; // [R14] [R22]
    end else begin
      if (div_wrap) begin
        tgl_cnt <= tgl_cnt + 9'h001;
      end
      half_tick_o <= 1'b0;
    end
  end

endmodule

//--- scc_clkout.sv
// Purpose: card clock pin drive selection
// Assumes: clock control bits come straight from the control register
// Notes: gsm off with upper bit set is treated as the lower bit alone
`timescale 1ns/1ns
module scc_clkout (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic gsm_select_i,
  input wire logic clk_out_ctl_hi_i,
  input wire logic clk_out_ctl_lo_i,
  input wire logic card_clk_i,
  // pin
  output logic card_clock_pin_o,
  output logic card_clock_pin_oe_o
);

  // ----------------------------------------
  // registered pin drive, glitch free
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      card_clock_pin_o <= 1'b0;
      card_clock_pin_oe_o <= 1'b0;
    end else if (clk_out_ctl_lo_i) begin
      card_clock_pin_o <= card_clk_i; // [R4] [R5] [R15]
      card_clock_pin_oe_o <= 1'b1;
    end else if (gsm_select_i) begin
      card_clock_pin_o <= clk_out_ctl_hi_i; // [R5]
      card_clock_pin_oe_o <= 1'b1;
    end else begin
      card_clock_pin_o <= 1'b0; // [R4]
      card_clock_pin_oe_o <= 1'b0;
    end
  end

endmodule

//--- scc_top.sv
// Purpose: card serial channel, register file, convention and frame engine
// Assumes: classic wishbone slave, open-drain data line with pull-up
// Notes: one character engine shared by transmit and receive
// Operation
// R1: seven byte registers at indices ffb0..ffb6 are decoded.
// R2: software keeps the fixed mode and control bits at their set values.
// R3: with gsm off, software keeps the upper clock-control bit zero.
// R4: regular mode: 00 stops card clock, 01 drives it on the pin.
// R5: gsm mode: clock output, or pin held fixed high or fixed low.
// R6: software clears gsm for regular cards, sets it for gsm mode.
// R7: direct convention: software clears parity-odd, bit-order and invert.
// R8: inverse convention: software sets bit-order, invert and parity-odd.
// R9: software sets the card-mode select bit to use the channel.
// R10: direct: high is 1, low is 0, least significant bit first.
// R11: inverse: low is 1, high is 0, most significant bit first.
// R12: inversion touches the eight data bits only, never parity.
// R13: characters carry even parity as seen on the line.
// R14: bit clock comes only from the internal rate generator.
// R15: card clock output runs at 372 times the bit rate.
// R16: bit rate is clock over 1488*2^(2n-1)*(divisor+1).
// R17: two prescale bits give n from 0 to 3 directly.
// R18: software loads a divisor 0..255 with the smaller error.
// R19: the generator counts the gear-divided system clock.
// R20: frame is low start bit, eight data bits, one parity bit.
// R21: receive parity error drives line low one bit time at 10.5.
// R22: down-counter reloads with divisor, ticking per full prescaled cycle.
`timescale 1ns/1ns
`include "scc_defs.svh"
module scc_top #(
  parameter int CLK_PER_ETU = `SCC_CARD_CLK_PER_ETU
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // gear-divided clock strobe, tie high for 1/1
  input wire logic phi_tick_i,
  // wishbone slave
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // card data line, open drain
  input wire logic sio_i,
  output logic sio_o,
  output logic sio_oe_o,
  // card clock pin
  output logic card_clock_pin_o,
  output logic card_clock_pin_oe_o
);
  import scc_pkg::*;

  // ----------------------------------------
  // registers and engine state
  // ----------------------------------------
  logic [7:0] serial_mode;
  logic [7:0] bit_rate_divisor;
  logic [7:0] serial_control;
  logic [7:0] transmit_holding;
  logic [7:0] serial_status;
  logic [7:0] receive_holding;
  logic [7:0] card_mode;
  scc_state_t state;
  scc_state_t next_state;
  logic [4:0] half_cnt;
  logic [8:0] shift;
  logic rx_par_bad;
  logic drive_low;
  logic half_tick;
  logic card_clk;
  logic restart;
  logic bus_req;
  logic wr_stb;
  logic [15:0] idx;
  logic idx_ok;
  logic [7:0] rd_byte;
  logic ev_txc;
  logic ev_rte;
  logic ev_rx_done;
  logic txe_clr;
  logic [7:0] rx_data;

  initial begin
    if (CLK_PER_ETU < 2 || CLK_PER_ETU > 511) $error("scc_top: CLK_PER_ETU out of range");
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7 - i];
    end
    return r;
  endfunction

  // character as it appears on the line, first bit in [0]
  function automatic logic [7:0] to_line(input logic [7:0] d, input logic inv, input logic msb);
    logic [7:0] t;
    t = inv ? ~d : d; // [R12]
    return msb ? rev8(t) : t; // [R10] [R11]
  endfunction

  function automatic logic [7:0] from_line(input logic [7:0] l, input logic inv, input logic msb);
    logic [7:0] t;
    t = msb ? rev8(l) : l; // [R10] [R11]
    return inv ? ~t : t; // [R12]
  endfunction

  // parity over the uninverted data; odd mode restores even on the line
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd; // [R12] [R13]
  endfunction

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  assign idx = adr_i[17:2];
  assign idx_ok = (adr_i[1:0] == 2'b00) && (adr_i[31:18] == 14'h0000) &&
                  (idx >= `SCC_IDX_MODE) && (idx <= `SCC_IDX_CMODE); // [R1]
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_stb = bus_req && we_i && sel_i[0] && idx_ok;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_comb begin
    case (idx)
      `SCC_IDX_MODE: rd_byte = serial_mode;
      `SCC_IDX_DIV: rd_byte = bit_rate_divisor;
      `SCC_IDX_CTRL: rd_byte = serial_control;
      `SCC_IDX_TXH: rd_byte = transmit_holding;
      `SCC_IDX_STAT: rd_byte = serial_status;
      `SCC_IDX_RXH: rd_byte = receive_holding;
      `SCC_IDX_CMODE: rd_byte = card_mode & 8'h0d;
      default: rd_byte = 8'h00;
    endcase
  end

  // unmapped reads answer zero
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_o <= {24'h00_0000, idx_ok ? rd_byte : 8'h00};
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // fixed bits are stored as written; software keeps them right
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_mode <= `SCC_RST_MODE;
      bit_rate_divisor <= `SCC_RST_DIV;
      serial_control <= `SCC_RST_CTRL;
      card_mode <= `SCC_RST_CMODE;
    end else if (wr_stb) begin
      case (idx)
        `SCC_IDX_MODE: serial_mode <= dat_i[7:0]; // [R2] [R6] [R7] [R8]
        `SCC_IDX_DIV: bit_rate_divisor <= dat_i[7:0]; // [R18]
        `SCC_IDX_CTRL: serial_control <= dat_i[7:0]; // [R2] [R3]
        `SCC_IDX_CMODE: card_mode <= dat_i[7:0] & 8'h0d; // [R9]
        default: card_mode <= card_mode;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      transmit_holding <= 8'h00;
    end else if (wr_stb && idx == `SCC_IDX_TXH) begin
      transmit_holding <= dat_i[7:0];
    end
  end

  // ----------------------------------------
  // status flags: write 0 clears, hardware set wins
  // ----------------------------------------
  assign txe_clr = wr_stb && idx == `SCC_IDX_STAT && !dat_i[`SCC_ST_TXE];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_status <= `SCC_RST_STAT;
    end else begin
      for (int b = 2; b < 8; b++) begin
        if (wr_stb && idx == `SCC_IDX_STAT && !dat_i[b]) begin
          serial_status[b] <= 1'b0;
        end
      end
      if (state == SCC_IDLE && next_state == SCC_TX) begin
        serial_status[`SCC_ST_TXC] <= 1'b0;
      end
      if (ev_txc) begin
        serial_status[`SCC_ST_TXC] <= 1'b1;
        serial_status[`SCC_ST_TXE] <= 1'b1;
      end
      if (ev_rte) begin
        serial_status[`SCC_ST_RTE] <= 1'b1;
      end
      if (ev_rx_done) begin
        if (serial_status[`SCC_ST_RXF]) begin
          serial_status[`SCC_ST_OVR] <= 1'b1;
        end else begin
          serial_status[`SCC_ST_RXF] <= 1'b1;
        end
        if (rx_par_bad) begin
          serial_status[`SCC_ST_PER] <= 1'b1;
        end
      end
      serial_status[1:0] <= 2'b00;
    end
  end

  // erroneous data is still handed over for inspection
  assign rx_data = from_line(shift[7:0], card_mode[`SCC_CM_INV], card_mode[`SCC_CM_MSB]);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      receive_holding <= 8'h00;
    end else if (ev_rx_done && !serial_status[`SCC_ST_RXF]) begin
      receive_holding <= rx_data;
    end
  end

  // ----------------------------------------
  // character engine
  // ----------------------------------------
  assign ev_txc = state == SCC_TX_WAIT && half_tick && !rx_par_bad && !ev_rte &&
                  half_cnt == (serial_mode[`SCC_MODE_GSM] ? `SCC_H_TXC_GSM : `SCC_H_TXC_REG);
  assign ev_rte = state == SCC_TX_WAIT && half_tick && half_cnt == `SCC_H_ERR_START && !sio_i;
  assign ev_rx_done = state == SCC_RX_END && half_tick && half_cnt == `SCC_H_ERR_END;
  assign restart = state == SCC_IDLE && next_state != SCC_IDLE;

  always_comb begin
    next_state = state;
    case (state)
      SCC_IDLE: begin
        if (card_mode[`SCC_CM_SEL] && serial_control[`SCC_CTRL_TXEN] &&
            !serial_status[`SCC_ST_TXE] && !txe_clr) begin
          next_state = SCC_TX;
        end else if (card_mode[`SCC_CM_SEL] && serial_control[`SCC_CTRL_RXEN] && !sio_i) begin
          next_state = SCC_RX;
        end
      end
      SCC_TX: begin
        if (half_tick && half_cnt == `SCC_H_LAST_BIT) begin
          next_state = SCC_TX_WAIT;
        end
      end
      SCC_TX_WAIT: begin
        if (ev_txc || !serial_control[`SCC_CTRL_TXEN]) begin
          next_state = SCC_IDLE;
        end else if (rx_par_bad && half_tick && half_cnt == `SCC_H_RETRY) begin
          next_state = SCC_TX;
        end
      end
      SCC_RX: begin
        if (half_tick && half_cnt == 5'd0 && sio_i) begin
          next_state = SCC_IDLE;
        end else if (half_tick && half_cnt == `SCC_H_LAST_BIT) begin
          next_state = SCC_RX_END;
        end
      end
      SCC_RX_END: begin
        if (ev_rx_done) begin
          next_state = SCC_IDLE;
        end
      end
      default: next_state = SCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SCC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // half bit times since the start edge; retry wraps back to a new frame
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_cnt <= 5'd0;
    end else if (restart) begin
      half_cnt <= 5'd0;
    end else if (state == SCC_TX_WAIT && rx_par_bad && half_tick && half_cnt == `SCC_H_RETRY) begin
      half_cnt <= 5'd0;
    end else if (half_tick) begin
      half_cnt <= half_cnt + 5'd1;
    end
  end

  // tx: {parity, data} shifted out, first line bit in [0]
  // rx: samples shift in at mid bit from the top
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift <= 9'h000;
    end else if (restart && next_state == SCC_TX) begin
      shift <= {par_of(transmit_holding, serial_mode[`SCC_MODE_ODD]),
                to_line(transmit_holding, card_mode[`SCC_CM_INV], card_mode[`SCC_CM_MSB])}; // [R20]
    end else if (state == SCC_TX && half_tick && half_cnt[0] && half_cnt != 5'd1) begin
      shift <= {1'b1, shift[8:1]};
    end else if (state == SCC_TX_WAIT && rx_par_bad && half_tick && half_cnt == `SCC_H_RETRY) begin
      shift <= {par_of(transmit_holding, serial_mode[`SCC_MODE_ODD]),
                to_line(transmit_holding, card_mode[`SCC_CM_INV], card_mode[`SCC_CM_MSB])};
    end else if (state == SCC_RX && half_tick && !half_cnt[0] && half_cnt != 5'd0) begin
      shift <= {sio_i, shift[8:1]}; // [R20]
    end
  end

  // rx: parity check result; tx: remembers a retransmit request
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_par_bad <= 1'b0;
    end else if (restart) begin
      rx_par_bad <= 1'b0;
    end else if (state == SCC_RX && next_state == SCC_RX_END) begin
      rx_par_bad <= shift[8] != par_of(rx_data, serial_mode[`SCC_MODE_ODD]); // [R13]
    end else if (ev_rte) begin
      rx_par_bad <= 1'b1;
    end else if (state == SCC_TX_WAIT && half_tick && half_cnt == `SCC_H_RETRY) begin
      rx_par_bad <= 1'b0;
    end
  end

  // ----------------------------------------
  // line drive: only ever pulls low
  // ----------------------------------------
  always_comb begin
    drive_low = 1'b0;
    case (state)
      SCC_TX: drive_low = (half_cnt < 5'd2) ? 1'b1 : !shift[0]; // [R10] [R11] [R20]
      SCC_RX_END: drive_low = rx_par_bad && half_cnt >= `SCC_H_ERR_START &&
                              half_cnt < `SCC_H_ERR_END; // [R21]
      default: drive_low = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sio_oe_o <= 1'b0;
    end else begin
      sio_oe_o <= drive_low;
    end
  end
  assign sio_o = 1'b0;

  // ----------------------------------------
  // rate generator and clock pin
  // ----------------------------------------
  scc_baud #(
    .CLK_PER_ETU(CLK_PER_ETU)
  ) u_baud (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .phi_tick_i(phi_tick_i), // [R19]
    .restart_i(restart),
    .prescale_sel_i(serial_mode[1:0]), // [R17]
    .rate_divisor_i(bit_rate_divisor), // [R16]
    .card_clk_o(card_clk),
    .half_tick_o(half_tick)
  );

  scc_clkout u_clkout (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .gsm_select_i(serial_mode[`SCC_MODE_GSM]),
    .clk_out_ctl_hi_i(serial_control[`SCC_CTRL_CKHI]),
    .clk_out_ctl_lo_i(serial_control[`SCC_CTRL_CKLO]),
    .card_clk_i(card_clk),
    .card_clock_pin_o(card_clock_pin_o),
    .card_clock_pin_oe_o(card_clock_pin_oe_o)
  );

endmodule

//--- scc_top_sva.sv
// Purpose: port assertions for the card serial block
// Assumes: byte address = 4 * register index
// Notes: shadows gsm and clock bits to know the pin mode
`timescale 1ns/1ns
`include "scc_defs.svh"
module scc_top_sva #(
  parameter int CLK_PER_ETU = `SCC_CARD_CLK_PER_ETU
) (
  // clock, reset, gear strobe
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic phi_tick_i,
  // bus
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // pins
  input wire logic sio_i,
  input wire logic sio_o,
  input wire logic sio_oe_o,
  input wire logic card_clock_pin_o,
  input wire logic card_clock_pin_oe_o
);
  // ----------------------------
  // pin configuration shadow
  // ----------------------------
  logic [2:0] cfg;
  wire logic [15:0] idx = adr_i[17:2];
  wire logic take = cyc_i && stb_i && !ack_o;
  wire logic aligned = adr_i[31:18] == 14'h0 && adr_i[1:0] == 2'h0;
  wire logic mapped = aligned && idx >= `SCC_IDX_MODE && idx <= `SCC_IDX_CMODE;

  // gsm in bit 2, clock control in bits 1:0
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cfg <= 3'h0;
    else if (take && we_i && sel_i[0] && aligned) begin
      if (idx == `SCC_IDX_MODE) cfg[2] <= dat_i[7];
      if (idx == `SCC_IDX_CTRL) cfg[1:0] <= dat_i[1:0];
    end
  end

  // ----------------------------
  // properties
  // ----------------------------
  // pin checks wait one stable cycle: the pin lags the write by a clock
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_ack_next: assert property (take |=> ack_o)
    else $error("request not acked one cycle later");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  a_unmapped_zero: assert property (take && !we_i && !mapped |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_line_open: assert property (sio_o == 1'b0)
    else $error("data line driven high");
  a_clk_off: assert property ($stable(cfg) && !cfg[2] && !cfg[0] |-> !card_clock_pin_oe_o)
    else $error("clock pin driven while off");
  a_clk_fixed: assert property ($stable(cfg) && cfg[2] && !cfg[0]
    |-> card_clock_pin_oe_o && card_clock_pin_o == cfg[1])
    else $error("clock pin not at fixed level");
  a_clk_on: assert property ($stable(cfg) && cfg[0] |-> card_clock_pin_oe_o)
    else $error("clock pin not driven while on");
endmodule

bind scc_top scc_top_sva #(.CLK_PER_ETU(CLK_PER_ETU)) u_sva (.clk_i(clk_i), .rstn_i(rstn_i),
  .phi_tick_i(phi_tick_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .sio_i(sio_i), .sio_o(sio_o), .sio_oe_o(sio_oe_o),
  .card_clock_pin_o(card_clock_pin_o), .card_clock_pin_oe_o(card_clock_pin_oe_o));

//--- scc_card_model.sv
// Purpose: smart card on the shared open-drain data line
// Assumes: line pulled up, so a released line reads high
// Notes: etu given in system clocks by the caller
`timescale 1ns/1ns
module scc_card_model (
  // clock
  input wire logic clk_i,
  // data line
  input wire logic line_i,
  output logic card_oe_o
);
  // ----------------------------
  // frames
  // ----------------------------
  initial card_oe_o = 1'b0;

  // send start then line levels lb[0..8]; error sampled at 11.0 etu
  task automatic send(input logic [8:0] lb, input int e, output logic err);
    @(posedge clk_i);
    card_oe_o <= 1'b1;
    repeat (e) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      card_oe_o <= !lb[i];
      repeat (e) @(posedge clk_i);
    end
    card_oe_o <= 1'b0;
    repeat (e) @(posedge clk_i);
    err = !line_i;
    repeat (e) @(posedge clk_i);
  endtask

  // mid-bit sampling; error signal leads a quarter etu so the sender sees it
  task automatic recv(input int e, input logic nack, output logic [8:0] lb);
    do @(posedge clk_i); while (line_i !== 1'b0);
    repeat (e / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (e) @(posedge clk_i);
      lb[i] = line_i;
    end
    if (nack) begin
      repeat (e * 3 / 4) @(posedge clk_i);
      card_oe_o <= 1'b1;
      repeat (e) @(posedge clk_i);
      card_oe_o <= 1'b0;
    end
  endtask
endmodule

//--- test_smart_card_serial_config.sv
// Purpose: bench for the card serial block
// Assumes: short etu parameter, card model on the line
// Notes: line levels come from the bench's own frame function
`timescale 1ns/1ns
`include "scc_defs.svh"
module test_smart_card_serial_config;
  // ----------------------------
  // signals and instances
  // ----------------------------
  localparam int C = 4;
  localparam int E = 2 * C * 2; // etu in clocks at n=0, divisor 1
  localparam logic [15:0] IX [6] = '{`SCC_IDX_MODE, `SCC_IDX_DIV, `SCC_IDX_CTRL, `SCC_IDX_STAT,
    `SCC_IDX_CMODE, 16'hffb7};
  localparam logic [7:0] R0 [6] = '{8'h00, 8'h00, 8'h00, 8'h84, 8'h00, 8'h00};
  localparam logic [7:0] WB [6] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h0d, 8'h00};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic phi_tick_i = 1'b1;
  logic gear = 1'b0;
  logic [31:0] adr_i = 32'h0;
  logic [31:0] dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic [31:0] dat_o;
  logic ack_o, sio_o, sio_oe_o, pin, pin_oe, card_oe, err;
  logic [7:0] rv, d;
  logic [8:0] lb;
  int n_mismatch = 0;
  int checked = 0;
  int hp;
  wire logic line = !((sio_oe_o && !sio_o) || card_oe);

  scc_top #(.CLK_PER_ETU(C)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .phi_tick_i(phi_tick_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
    .sio_i(line), .sio_o(sio_o), .sio_oe_o(sio_oe_o), .card_clock_pin_o(pin), .card_clock_pin_oe_o(pin_oe));
  scc_card_model card (.clk_i(clk_i), .line_i(line), .card_oe_o(card_oe));

  initial forever #4 clk_i = ~clk_i;
  // gear mode halves the counted clock
  always @(posedge clk_i) phi_tick_i <= gear ? !phi_tick_i : 1'b1;

  // ----------------------------
  // tasks
  // ----------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] v);
    @(posedge clk_i);
    adr_i <= {14'h0, idx, 2'b00};
    dat_i <= {24'h0, v};
    sel_i <= 4'h1;
    we_i <= w;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rv = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    bus(1'b1, idx, v);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rv, exp);
  endtask

  // pin changes twice to settle, then one half period in clocks
  task automatic meas(output int cnt);
    logic p;
    repeat (2) begin
      p = pin;
      while (pin === p) @(posedge clk_i);
    end
    p = pin;
    cnt = 0;
    while (pin === p) begin
      @(posedge clk_i);
      cnt++;
    end
  endtask

  function automatic logic [8:0] frame_of(input logic [7:0] dv, input logic c);
    logic [8:0] f;
    for (int i = 0; i < 8; i++) f[i] = (c ? dv[7 - i] : dv[i]) ^ c;
    f[8] = ^dv ^ c;
    return f;
  endfunction

  task automatic results();
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------
  // tests
  // ----------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(IX[i], R0[i]);
    for (int i = 0; i < 6; i++) begin
      if (i != 3) begin
        wr(IX[i], 8'hff);
        rdchk(IX[i], WB[i]);
      end
    end
    wr(`SCC_IDX_TXH, 8'h5a);
    rdchk(`SCC_IDX_TXH, 8'h5a);
    wr(`SCC_IDX_CMODE, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wr(`SCC_IDX_MODE, {k > 0, 7'h28});
      wr(`SCC_IDX_CTRL, {6'h0, k == 2, 1'b0});
      repeat (3) @(posedge clk_i);
      chk(pin_oe, k > 0);
      if (k > 0) chk(pin, k == 2);
    end
    wr(`SCC_IDX_DIV, 8'h01);
    for (int n = 0; n < 5; n++) begin
      gear <= (n == 4);
      wr(`SCC_IDX_MODE, {n == 1, 5'h0a, 2'(n)});
      wr(`SCC_IDX_CTRL, 8'h01);
      meas(hp);
      chk(16'(hp), 16'((2 << (2 * (n % 4))) * (1 + (n == 4))));
    end
    gear <= 1'b0;
    for (int c = 0; c < 2; c++) begin
      d = c ? 8'h3f : 8'h3b;
      wr(`SCC_IDX_CMODE, c ? 8'h0d : 8'h01);
      wr(`SCC_IDX_MODE, {3'b001, c[0], 4'h8});
      wr(`SCC_IDX_CTRL, 8'h21);
      wr(`SCC_IDX_TXH, d);
      wr(`SCC_IDX_STAT, 8'h00);
      card.recv(E, 1'b1, lb);
      chk(lb, frame_of(d, c[0]));
      card.recv(E, 1'b0, lb);
      chk(lb, frame_of(d, c[0]));
      repeat (4 * E) @(posedge clk_i);
      rdchk(`SCC_IDX_STAT, 8'h94);
      wr(`SCC_IDX_STAT, 8'hef);
      wr(`SCC_IDX_CTRL, 8'h11);
      for (int b = 0; b < 2; b++) begin
        wr(`SCC_IDX_STAT, 8'h84);
        d = 8'ha6 ^ {8{c[0]}};
        card.send(frame_of(d, c[0]) ^ {b[0], 8'h00}, E, err);
        chk(err, b[0]);
        repeat (E) @(posedge clk_i);
        rdchk(`SCC_IDX_RXH, d);
        rdchk(`SCC_IDX_STAT, b[0] ? 8'hcc : 8'hc4);
      end
    end
    results();
  end
endmodule
